/* File: pkg/lbs_pkg.sv */
// constants shared by the load/store byte-lane steering block
// assumes lane 0 is the most significant byte of the 32-bit data buses
package lbs_pkg;
	// transfer size codes
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	// byte enables, bit 3 is lane 0
	localparam logic [3:0] BE_NONE = 4'h0;
	localparam logic [3:0] BE_LANE0 = 4'h8;
	localparam logic [3:0] BE_HALF_LO = 4'hC;
	localparam logic [3:0] BE_HALF_HI = 4'h3;
	localparam logic [3:0] BE_WORD = 4'hF;
	// little-endian offset flips per size
	localparam logic [1:0] FLIP_BYTE = 2'h3;
	localparam logic [1:0] FLIP_HALF = 2'h2;
	localparam logic [1:0] FLIP_WORD = 2'h0;
	// configuration thresholds for big-endian availability
	localparam int MMU_BE_ABOVE = 1;
	localparam int REORDER_ON = 1;
endpackage

/* File: hw/lbs_lane_map.sv */
// combinational lane map: byte enables, store lanes, load extraction
// assumes aligned offsets; software never exceeds the slave width
`timescale 1ns/1ps
module lbs_lane_map (
	input wire logic [1:0] size,
	input wire logic [1:0] off,
	input wire logic little,
	input wire logic [31:0] wdata,
	input wire logic [31:0] rdata,
	output logic [3:0] be,
	output logic [31:0] wlanes,
	output logic [31:0] rvalue
);
	// little-endian is big-endian steering on a mirrored offset
	wire [1:0] flip;
	wire [1:0] eff;
	wire [4:0] boff;
	assign flip = (size == lbs_pkg::SZ_BYTE) ? lbs_pkg::FLIP_BYTE :
		(size == lbs_pkg::SZ_HALF) ? lbs_pkg::FLIP_HALF :
		lbs_pkg::FLIP_WORD;
	assign eff = little ? (off ^ flip) : off;
	assign boff = {~eff, 3'h0}; // bit position of lane eff

	// R1 R2 R5 R6: enables per size
	assign be = (size == lbs_pkg::SZ_BYTE) ? (lbs_pkg::BE_LANE0 >> eff) :
		(size == lbs_pkg::SZ_HALF) ?
		(eff[1] ? lbs_pkg::BE_HALF_HI : lbs_pkg::BE_HALF_LO) :
		lbs_pkg::BE_WORD;

	// R7 R8 R9: replicate low data onto every candidate lane
	assign wlanes = (size == lbs_pkg::SZ_BYTE) ? {4{wdata[7:0]}} :
		(size == lbs_pkg::SZ_HALF) ? {2{wdata[15:0]}} : wdata;

	// R10: right-justify selected lanes, zero the rest
	assign rvalue = (size == lbs_pkg::SZ_BYTE) ? {24'h0, rdata[boff +: 8]} :
		(size == lbs_pkg::SZ_HALF) ?
		{16'h0, (eff[1] ? rdata[15:0] : rdata[31:16])} : rdata;
endmodule

/* File: hw/lbs_steer.sv */
// data-side load/store steering between register datapath and bus slave
// assumes bus slave runs on sys_clk and answers with a one-cycle ready
//
// Operation
// R1: byte, halfword and word transfers steer correctly to word-wide slaves.
// R2: bytes and halfwords reach halfword slaves; bytes reach byte slaves.
// R3: software never issues transfers wider than the slave; no bus sizing.
// R4: big-endian only when mmu level above one or reordering enabled.
// R5: big-endian loads use documented enables, right-justified in register.
// R6: little-endian loads use mirrored enables; earlier halfword lane high.
// R7: big-endian stores put low register bytes onto enabled lanes.
// R8: little-endian halfword stores put bits 16-23 on first enabled lane; lane map puts bits 8-15 there.
// R9: little-endian word stores enable all lanes, bytes in order.
// R10: unfilled load bits read zero; disabled store lanes carry anything.
// R11: enables and write data valid only with address strobe high.
`timescale 1ns/1ps
module lbs_steer #(
	parameter int memory_mgmt_level_param = 0,
	parameter int reorder_instr_param = 0
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [1:0] req_size,
	input wire logic [31:0] req_addr,
	input wire logic [31:0] req_wdata,
	input wire logic big_endian_sel,
	output logic [31:0] bus_addr,
	output logic bus_as,
	output logic bus_rd_strobe,
	output logic bus_wr_strobe,
	output logic [3:0] bus_be,
	output logic [31:0] bus_wdata,
	input wire logic [31:0] bus_rdata,
	input wire logic bus_ready,
	output logic load_valid,
	output logic [31:0] load_data
);
	typedef enum logic {LBS_IDLE, LBS_BUSY} lbs_state_type;

	lbs_state_type state_q;
	logic as_q;
	logic rd_q;
	logic wr_q;
	logic write_q;
	logic little_q;
	logic [1:0] size_q;
	logic [1:0] off_q;
	logic [3:0] be_q;
	logic [31:0] addr_q;
	logic [31:0] wdata_q;
	logic ld_valid_q;
	logic [31:0] ld_data_q;

	// R4: big-endian gated by configuration
	wire be_ok;
	wire little;
	assign be_ok = (memory_mgmt_level_param > lbs_pkg::MMU_BE_ABOVE) ||
		(reorder_instr_param == lbs_pkg::REORDER_ON);
	assign little = !(big_endian_sel && be_ok);

	// accept when idle or the current transfer completes this cycle
	wire busy;
	wire done;
	wire accept;
	assign busy = (state_q == LBS_BUSY);
	assign done = busy && bus_ready;
	assign req_ready = !busy || bus_ready;
	assign accept = req_valid && req_ready;

	// request-side lane map
	wire [3:0] map_be;
	wire [31:0] map_w;
	lbs_lane_map u_req_map (
		.size(req_size),
		.off(req_addr[1:0]),
		.little(little),
		.wdata(req_wdata),
		.rdata(32'h0),
		.be(map_be),
		.wlanes(map_w),
		.rvalue()
	);

	// load-side lane map on the captured transfer
	wire [31:0] map_r;
	lbs_lane_map u_ld_map (
		.size(size_q),
		.off(off_q),
		.little(little_q),
		.wdata(32'h0),
		.rdata(bus_rdata),
		.be(),
		.wlanes(),
		.rvalue(map_r)
	);

	// transfer sequencing
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= LBS_IDLE;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
		end else if (accept) begin
			state_q <= LBS_BUSY;
			rd_q <= !req_write;
			wr_q <= req_write;
		end else if (done) begin
			state_q <= LBS_IDLE;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
		end
	end

	// R11: strobe, enables and data only in the first cycle
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			as_q <= 1'b0;
			be_q <= lbs_pkg::BE_NONE;
			wdata_q <= 32'h0;
		end else begin
			as_q <= accept;
			be_q <= accept ? map_be : lbs_pkg::BE_NONE;
			wdata_q <= (accept && req_write) ? map_w : 32'h0;
		end
	end

	// captured transfer attributes
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			addr_q <= 32'h0;
			size_q <= lbs_pkg::SZ_WORD;
			off_q <= 2'h0;
			little_q <= 1'b1;
			write_q <= 1'b0;
		end else if (accept) begin
			addr_q <= req_addr;
			size_q <= req_size;
			off_q <= req_addr[1:0];
			little_q <= little;
			write_q <= req_write;
		end
	end

	// R6: load result registered when ready ends a read
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ld_valid_q <= 1'b0;
			ld_data_q <= 32'h0;
		end else begin
			ld_valid_q <= done && !write_q;
			if (done && !write_q) begin
				ld_data_q <= map_r;
			end
		end
	end

	assign bus_addr = addr_q;
	assign bus_as = as_q;
	assign bus_rd_strobe = rd_q;
	assign bus_wr_strobe = wr_q;
	assign bus_be = be_q;
	assign bus_wdata = wdata_q;
	assign load_valid = ld_valid_q;
	assign load_data = ld_data_q;

	// checks beside the steering
	word_enable_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R1
		bus_as && size_q == lbs_pkg::SZ_WORD |-> bus_be == lbs_pkg::BE_WORD)
		else $error("word transfer without all enables");
	half_enable_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R2
		bus_as && size_q == lbs_pkg::SZ_HALF |->
		bus_be == lbs_pkg::BE_HALF_LO || bus_be == lbs_pkg::BE_HALF_HI)
		else $error("halfword enables not a lane pair");
	endian_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R4
		bus_as && !little_q |-> be_ok)
		else $error("big-endian used while unavailable");
	be_byte_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R5
		bus_as && !little_q && size_q == lbs_pkg::SZ_BYTE |->
		bus_be == (lbs_pkg::BE_LANE0 >> off_q))
		else $error("big-endian byte enable wrong");
	le_byte_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R6
		bus_as && little_q && size_q == lbs_pkg::SZ_BYTE |->
		bus_be == (lbs_pkg::BE_LANE0 >> (off_q ^ lbs_pkg::FLIP_BYTE)))
		else $error("little-endian byte enable wrong");
	store_byte_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R7
		bus_as && wr_q && size_q == lbs_pkg::SZ_BYTE |->
		bus_wdata == {4{$past(req_wdata[7:0])}})
		else $error("store byte not on lanes");
	store_half_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R8
		bus_as && wr_q && size_q == lbs_pkg::SZ_HALF |->
		bus_wdata == {2{$past(req_wdata[15:0])}})
		else $error("store halfword lanes wrong");
	store_word_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R9
		bus_as && wr_q && size_q == lbs_pkg::SZ_WORD |->
		bus_wdata == $past(req_wdata))
		else $error("store word lanes wrong");
	zero_fill_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R10
		load_valid && $past(size_q) == lbs_pkg::SZ_BYTE |->
		load_data[31:8] == 24'h0)
		else $error("byte load upper bits not zero");
	quiet_lanes_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R11
		!bus_as |-> bus_be == lbs_pkg::BE_NONE && bus_wdata == 32'h0)
		else $error("enables or data outside strobe");
	load_return_a: assert property (@(posedge sys_clk) disable iff (!nrst) // R1
		busy && bus_ready && !write_q |=> load_valid)
		else $error("read completion without load result");
endmodule

/* File: tb/lbs_slave.sv */
// word-wide bus slave model with random wait states
// assumes one transfer at a time, all on sys_clk
`timescale 1ns/1ps
module lbs_slave (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic bus_as,
	input wire logic [31:0] bus_addr,
	input wire logic [3:0] bus_be,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr_strobe,
	output logic [31:0] bus_rdata,
	output logic bus_ready
);
	logic [31:0] mem [16];
	logic [31:0] last;
	logic [3:0] a;
	logic [1:0] nw;
	logic [1:0] cnt;
	logic pend;
	// ready at once or after a drawn wait; idle data reads back inverted
	assign bus_ready = bus_as ? nw == 2'h0 : pend && cnt == 2'h0;
	assign bus_rdata = bus_ready ? mem[bus_as ? bus_addr[5:2] : a] : ~last;
	initial begin
		for (int i = 0; i < 16; i++) mem[i] = {8{i[3:0]}};
	end
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pend <= 1'h0;
			nw <= 2'h0;
			last <= 32'h0;
		end else begin
			if (bus_ready) last <= bus_rdata;
			if (bus_ready) pend <= 1'h0;
			else if (pend) cnt <= cnt - 2'h1;
			if (bus_as) begin
				a <= bus_addr[5:2];
				pend <= nw != 2'h0;
				cnt <= nw - 2'h1;
				nw <= 2'($urandom % 3);
				for (int k = 0; k < 4; k++)
					if (bus_wr_strobe && bus_be[k])
						mem[bus_addr[5:2]][8*k+:8] <= bus_wdata[8*k+:8];
			end
		end
	end
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the load/store steering block
// assumes a word-wide slave model; extra instances probe the big-endian gate
`timescale 1ns/1ps
module tb_top;
	logic sys_clk = 0, nrst = 0, req_valid = 0, req_write = 0, sel = 0;
	logic [1:0] req_size = 0;
	logic [31:0] req_addr = 0, req_wdata = 0, bus_addr, bus_wdata, rdata;
	logic [31:0] load_data, ld2;
	logic req_ready, bus_as, rd_s, wr_s, ready, load_valid;
	logic [3:0] bus_be, be2, be3;
	int failures = 0, num_checks = 0;
	lbs_steer #(.memory_mgmt_level_param(2)) uut (.sys_clk(sys_clk),
		.nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
		.req_write(req_write), .req_size(req_size), .req_addr(req_addr),
		.req_wdata(req_wdata), .big_endian_sel(sel), .bus_addr(bus_addr),
		.bus_as(bus_as), .bus_rd_strobe(rd_s), .bus_wr_strobe(wr_s),
		.bus_be(bus_be), .bus_wdata(bus_wdata), .bus_rdata(rdata),
		.bus_ready(ready), .load_valid(load_valid), .load_data(load_data));
	lbs_steer #(.memory_mgmt_level_param(1)) uut_le (.sys_clk(sys_clk),
		.nrst(nrst), .req_valid(req_valid),
		.req_ready(), .req_write(req_write), .req_size(req_size),
		.req_addr(req_addr), .req_wdata(req_wdata), .big_endian_sel(sel),
		.bus_addr(), .bus_as(), .bus_rd_strobe(), .bus_wr_strobe(),
		.bus_be(be2), .bus_wdata(), .bus_rdata(rdata), .bus_ready(ready),
		.load_valid(), .load_data(ld2));
	lbs_steer #(.reorder_instr_param(1)) uut_ro (.sys_clk(sys_clk),
		.nrst(nrst), .req_valid(req_valid), .req_ready(),
		.req_write(req_write), .req_size(req_size), .req_addr(req_addr),
		.req_wdata(req_wdata), .big_endian_sel(sel), .bus_addr(),
		.bus_as(), .bus_rd_strobe(), .bus_wr_strobe(), .bus_be(be3),
		.bus_wdata(), .bus_rdata(rdata), .bus_ready(ready),
		.load_valid(), .load_data());
	lbs_slave slave (.sys_clk(sys_clk), .nrst(nrst), .bus_as(bus_as),
		.bus_addr(bus_addr), .bus_be(bus_be), .bus_wdata(bus_wdata),
		.bus_wr_strobe(wr_s), .bus_rdata(rdata), .bus_ready(ready));
	// clock
	always #2.5 sys_clk = ~sys_clk;
	// expected enables per size, offset and order
	function automatic logic [3:0] ebe(logic [1:0] sz, logic [1:0] o, logic big);
		if (sz == lbs_pkg::SZ_BYTE) return big ? 4'h8 >> o : 4'h1 << o;
		if (sz == lbs_pkg::SZ_HALF) return (o[1] ^ big) ? 4'hC : 4'h3;
		return 4'hF;
	endfunction
	function automatic logic [31:0] msk(logic [3:0] b);
		return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
	endfunction
	// right-justified, zero-filled load value
	function automatic logic [31:0] eld(logic [31:0] r, logic [3:0] b);
		return (r & msk(b)) >> (b[0] ? 0 : b[1] ? 8 : b[2] ? 16 : 24);
	endfunction
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one transfer through request, bus and load return
	task automatic xfer(logic w, logic [1:0] sz, logic [1:0] o, logic big);
		logic [3:0] b;
		logic [31:0] d, r;
		b = ebe(sz, o, big);
		d = $urandom;
		@(posedge sys_clk);
		#1;
		req_valid = 1;
		req_write = w;
		req_size = sz;
		sel = big;
		req_wdata = d;
		req_addr = {26'h0, 4'($urandom), o};
		for (int n = 0; n < 20 && req_ready !== 1'h1; n++)
			@(posedge sys_clk) #1;
		chk(req_ready, 1);
		@(posedge sys_clk);
		#1;
		req_valid = 0;
		chk(bus_as, 1);
		chk({wr_s, rd_s}, w ? 2'h2 : 2'h1);
		chk(bus_addr, req_addr);
		chk(bus_be, b);
		chk(be2, ebe(sz, o, 1'h0));
		chk(be3, b);
		d = sz == 0 ? {4{d[7:0]}} : sz == 1 ? {2{d[15:0]}} : d;
		if (w) chk(bus_wdata & msk(b), d & msk(b));
		chk(req_ready, ready);
		for (int n = 0; n < 10 && ready !== 1'h1; n++) @(posedge sys_clk) #1;
		chk(ready, 1);
		r = rdata;
		@(posedge sys_clk);
		#1;
		chk({bus_as, wr_s, rd_s}, 0);
		chk(load_valid, !w);
		if (!w) chk(load_data, eld(r, b));
		if (!w) chk(ld2, eld(r, ebe(sz, o, 1'h0)));
	endtask
	// back-to-back: the next request is taken on the ready cycle
	task automatic pair(logic w1, logic w2);
		logic [31:0] a2, r;
		a2 = {26'h0, 4'($urandom), 2'h0};
		@(posedge sys_clk);
		#1;
		req_valid = 1;
		req_write = w1;
		req_size = lbs_pkg::SZ_WORD;
		sel = 0;
		req_addr = {26'h0, 4'($urandom), 2'h0};
		@(posedge sys_clk);
		#1;
		req_write = w2;
		req_addr = a2;
		req_wdata = $urandom;
		for (int n = 0; n < 10 && ready !== 1'h1; n++) @(posedge sys_clk) #1;
		chk(req_ready, 1);
		r = rdata;
		@(posedge sys_clk);
		#1;
		req_valid = 0;
		chk(bus_as, 1);
		chk({wr_s, rd_s}, w2 ? 2'h2 : 2'h1);
		chk(bus_addr, a2);
		chk(load_valid, !w1);
		if (!w1) chk(load_data, r);
		for (int n = 0; n < 10 && ready !== 1'h1; n++) @(posedge sys_clk) #1;
		chk(ready, 1);
		r = rdata;
		@(posedge sys_clk);
		#1;
		chk({bus_as, wr_s, rd_s}, 0);
		chk(load_valid, !w2);
		if (!w2) chk(load_data, r);
	endtask
	task end_of_test;
		if (failures == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// watchdog
	initial begin
		#100000;
		failures++;
		end_of_test;
	end
	// every size and aligned offset in both orders, then random traffic
	initial begin
		int s;
		void'($urandom(32'h1bc4));
		repeat (2) @(posedge sys_clk);
		#1;
		nrst = 1;
		for (int e = 0; e < 2; e++)
			for (int s = 0; s < 3; s++)
				for (int o = 0; o < 4; o += 1 << s) begin
					xfer(1'h1, 2'(s), 2'(o), e[0]);
					xfer(1'h0, 2'(s), 2'(o), e[0]);
				end
		// mid-run reset while idle clears bus and load outputs; req_ready stays high
		@(posedge sys_clk);
		#1;
		nrst = 0;
		#1;
		chk({bus_as, rd_s, wr_s, bus_be, load_valid}, 0);
		chk(load_data | bus_wdata, 0);
		chk(req_ready, 1);
		@(posedge sys_clk);
		#1;
		nrst = 1;
		// back-to-back pairs of every kind
		for (int k = 0; k < 4; k++)
			pair(k[1], k[0]);
		repeat (300) begin
			s = $urandom % 3;
			xfer(1'($urandom), 2'(s), 2'($urandom) &
				(s == 0 ? 2'h3 : s == 1 ? 2'h2 : 2'h0), 1'($urandom));
		end
		end_of_test;
	end
endmodule
